// file: hdl/rlw_params.svh
// Constants for the reset, LED, wake and pin logic block
`ifndef RLW_PARAMS_SVH
`define RLW_PARAMS_SVH
`define RLW_CLK_MHZ    250
`define RLW_POR_MS     5
`define RLW_POR_CYC    (`RLW_POR_MS * `RLW_CLK_MHZ * 1000)
`define RLW_LED_MS     5
`define RLW_LED_CYC    (`RLW_LED_MS * `RLW_CLK_MHZ * 1000)
`define RLW_RI_MS      20
`define RLW_RI_CYC     (`RLW_RI_MS * `RLW_CLK_MHZ * 1000)
`define RLW_BAUD       115200
`define RLW_BIT_CYC    ((`RLW_CLK_MHZ * 1000000) / `RLW_BAUD)
`define RLW_MULT       8
`define RLW_DATA_W     8
`define RLW_FIFO_DEPTH 16
`define RLW_LONG_W     23
`define RLW_PER_W      8
`define RLW_BIT_W      12
`define RLW_TXD_IDLE   1'b1
`endif

// file: hdl/rlw_pkg.sv
// Types shared by the reset, LED, wake and pin logic block
`include "rlw_params.svh"
package rlw_pkg;
  typedef logic [`RLW_DATA_W-1:0] rlw_byte_t;
  typedef logic [`RLW_LONG_W-1:0] rlw_long_t;
  typedef enum logic [0:0] {POR_WAIT = 1'b0, POR_DONE = 1'b1} rlw_por_e;
  typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} rlw_tx_e;
  typedef enum logic [0:0] {RX_IDLE = 1'b0, RX_BUSY = 1'b1} rlw_rx_e;
endpackage : rlw_pkg

// file: hdl/rlw_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/100ps
module rlw_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clr,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // Honest flags straight from the occupancy count
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];

  // Storage entries, one per slot
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (push && wr_q == AW'(i)) mem_q[i] <= in_data;
    end
  end

  // Pointers and count; clear drops all contents
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (clr) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + AW'(1);
      if (pop) rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : rlw_fifo

// file: hdl/rlw_stretch.sv
// Retriggerable pulse stretcher for an open-collector LED pin
`timescale 1ns/100ps
module rlw_stretch #(
  parameter int unsigned CYC = 1250000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic clr,
  // Event in, pin enable out (low pulls the LED low)
  input  wire logic trig,
  output logic      oe_n
);
  import rlw_pkg::*;
  rlw_long_t cnt_q;
  rlw_long_t cnt_d;

  // Each new event restarts the full on-time
  assign cnt_d = clr ? '0 :
                 trig ? rlw_long_t'(CYC) :
                 (cnt_q != '0) ? cnt_q - rlw_long_t'(1) : cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      oe_n  <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      oe_n  <= (cnt_d == '0);
    end
  end
endmodule : rlw_stretch

// file: hdl/rlw_top.sv
// Reset generator, LEDs, clock reference, wakeup and serial pins
// Function
// RL1: Low external reset input resets the device
// RL2: Reset out floats 5 ms, then drives high
// RL3: External reset low forces reset out low
// RL4: USB bus reset never touches reset out
// RL5: Transmit LED pulses low on USB send
// RL6: Receive LED pulses low on USB receive
// RL7: Reference comes from 6 MHz crystal or clock
// RL8: Working clock is reference times eight
// RL9: Oscillator output stops during USB suspend
// RL10: Ring low 20 ms wakes suspended host
// RL11: Board holds test input low normally
// RL12: Serial data out on TX, in on RX
// RL13: RS485 driver enabled while transmitting
// RL14: Drive active-low request-to-send output
// RL15: Sample active-low data-set-ready input
// RL16: Sample active-low carrier-detect input
// RL17: Suspend indicator low during USB suspend
// RL18: LED pulses visible and retriggered
`timescale 1ns/100ps
`include "rlw_params.svh"
module rlw_top #(
  parameter int unsigned POR_CYCLES = `RLW_POR_CYC,
  parameter int unsigned LED_CYCLES = `RLW_LED_CYC,
  parameter int unsigned RI_CYCLES  = `RLW_RI_CYC
) (
  // Clock and power-on reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // External reset and generated reset pin
  input  wire logic        RESET_N_IN,
  output logic             GEN_RESET_OUT_N_O,
  output logic             GEN_RESET_OUT_N_OE_N,
  // Activity LED pins, open collector
  output logic             TX_ACTIVITY_LED_N_O,
  output logic             TX_ACTIVITY_LED_N_OE_N,
  output logic             RX_ACTIVITY_LED_N_O,
  output logic             RX_ACTIVITY_LED_N_OE_N,
  // Oscillator reference and derived clock
  input  wire logic        OSC_REF_IN,
  output logic             OSC_REF_OUT,
  output logic             WORK_CLK_TICK,
  output logic             REF_LOCK,
  // USB link state
  input  wire logic        USB_SUSPEND,
  input  wire logic        USB_IN_XFER,
  input  wire logic        USB_OUT_XFER,
  input  wire logic        REMOTE_WAKE_EN,
  output logic             SUSPEND_N,
  output logic             RESUME_REQ,
  // Host to serial byte stream
  input  wire logic        USB_OUT_VALID,
  output logic             USB_OUT_READY,
  input  rlw_pkg::rlw_byte_t USB_OUT_DATA,
  // Serial to host byte stream
  output logic             USB_IN_VALID,
  output rlw_pkg::rlw_byte_t USB_IN_DATA,
  // Serial and modem pins
  output logic             SER_TX_DATA,
  input  wire logic        SER_RX_DATA,
  output logic             RS485_DRIVER_ENABLE,
  input  wire logic        RTS_REQ,
  output logic             REQ_TO_SEND_N,
  input  wire logic        DATA_SET_READY_N,
  input  wire logic        CARRIER_DETECT_N,
  input  wire logic        RING_INDICATOR_N,
  output logic             DSR_STAT,
  output logic             CD_STAT,
  output logic             RI_STAT
);
  import rlw_pkg::*;

  localparam int unsigned BITC = `RLW_BIT_CYC;
  localparam logic [`RLW_PER_W-1:0] PER_MAX = '1;

  // Device reset from the external pin, sampled once.
  // Powers up released, so the reset pin floats from the first edge.
  logic ext_rst_n_q;
  wire  dev_rst = ~ext_rst_n_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) ext_rst_n_q <= 1'b1;
    else ext_rst_n_q <= RESET_N_IN;   // [RL1]
  end

  // Reference edge detection and period measurement
  logic                  ref_q;
  logic                  ref_prev_q;
  logic [`RLW_PER_W-1:0] per_cnt_q;
  logic [`RLW_PER_W-1:0] period_q;
  logic [`RLW_PER_W:0]   phase_q;
  wire                   ref_rise = ref_q & ~ref_prev_q;
  wire                   ref_lost = (per_cnt_q == PER_MAX);
  wire                   lock     = (period_q != '0);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ref_q      <= 1'b0;
      ref_prev_q <= 1'b0;
      per_cnt_q  <= '0;
      period_q   <= '0;
    end else begin
      ref_q      <= OSC_REF_IN;       // [RL7]
      ref_prev_q <= ref_q;
      if (ref_rise) begin
        per_cnt_q <= '0;
        period_q  <= ref_lost ? '0 : per_cnt_q + `RLW_PER_W'(1);
      end else if (ref_lost) begin
        period_q  <= '0;              // Reference stopped
      end else begin
        per_cnt_q <= per_cnt_q + `RLW_PER_W'(1);
      end
    end
  end

  // Times-eight tick: add eight per cycle, wrap on the period.
  // Jitter is one core cycle; the average rate is exact.
  wire [`RLW_PER_W:0] phase_sum = phase_q + (`RLW_PER_W+1)'(`RLW_MULT);
  wire [`RLW_PER_W:0] per_ext   = {1'b0, period_q};
  wire                tick_hit  = lock && (phase_sum >= per_ext);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      phase_q       <= '0;
      WORK_CLK_TICK <= 1'b0;
      REF_LOCK      <= 1'b0;
    end else begin
      phase_q       <= !lock ? '0 :
                       tick_hit ? phase_sum - per_ext : phase_sum;
      WORK_CLK_TICK <= tick_hit;      // [RL8]
      REF_LOCK      <= lock;
    end
  end

  // Oscillator output pin is held low in suspend
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      OSC_REF_OUT <= 1'b0;
      SUSPEND_N   <= 1'b1;
    end else begin
      OSC_REF_OUT <= USB_SUSPEND ? 1'b0 : ref_q;   // [RL9]
      SUSPEND_N   <= ~USB_SUSPEND;                 // [RL17]
    end
  end

  // Power-up delay, counted only once the reference runs
  rlw_por_e  por_q;
  rlw_long_t por_cnt_q;
  wire       por_end = (por_cnt_q == rlw_long_t'(POR_CYCLES - 1));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      por_q     <= POR_WAIT;
      por_cnt_q <= '0;
    end else begin
      unique case (por_q)
        POR_WAIT: begin
          if (lock) begin
            por_cnt_q <= por_cnt_q + rlw_long_t'(1);
            if (por_end) por_q <= POR_DONE;     // [RL2]
          end
        end
        POR_DONE: begin
          por_q <= POR_DONE;
        end
      endcase
    end
  end

  // Reset pin: low on external reset, else float until done.
  // No USB bus reset path exists into this logic.
  wire rst_pin_o    = ext_rst_n_q & (por_q == POR_DONE);
  wire rst_pin_oe_n = ext_rst_n_q & (por_q == POR_WAIT);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      GEN_RESET_OUT_N_O    <= 1'b0;
      GEN_RESET_OUT_N_OE_N <= 1'b1;
    end else begin
      GEN_RESET_OUT_N_O    <= rst_pin_o;       // [RL2] [RL3] [RL4]
      GEN_RESET_OUT_N_OE_N <= rst_pin_oe_n;    // [RL3]
    end
  end

  // Activity LEDs; the pin only ever pulls low
  assign TX_ACTIVITY_LED_N_O = 1'b0;
  assign RX_ACTIVITY_LED_N_O = 1'b0;

  rlw_stretch #(.CYC(LED_CYCLES)) u_tx_led (
    .clk  (CORE_CLK),
    .rst  (RST),
    .clr  (dev_rst),
    .trig (USB_IN_XFER),            // [RL5] [RL18]
    .oe_n (TX_ACTIVITY_LED_N_OE_N)
  );

  rlw_stretch #(.CYC(LED_CYCLES)) u_rx_led (
    .clk  (CORE_CLK),
    .rst  (RST),
    .clr  (dev_rst),
    .trig (USB_OUT_XFER),           // [RL6] [RL18]
    .oe_n (RX_ACTIVITY_LED_N_OE_N)
  );

  // Remote wakeup: ring low long enough while suspended.
  // One request per ring pulse; release of ring re-arms it.
  rlw_long_t ri_cnt_q;
  logic      ri_done_q;
  wire       ri_arm = USB_SUSPEND & REMOTE_WAKE_EN & ~RING_INDICATOR_N;
  wire       ri_hit = ri_arm & ~ri_done_q &
                      (ri_cnt_q == rlw_long_t'(RI_CYCLES - 1));

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      ri_cnt_q   <= '0;
      ri_done_q  <= 1'b0;
      RESUME_REQ <= 1'b0;
    end else if (dev_rst || !ri_arm) begin
      ri_cnt_q   <= '0;
      ri_done_q  <= 1'b0;
      RESUME_REQ <= 1'b0;
    end else begin
      if (!ri_done_q) ri_cnt_q <= ri_cnt_q + rlw_long_t'(1);
      if (ri_hit) ri_done_q <= 1'b1;
      RESUME_REQ <= ri_hit;                    // [RL10]
    end
  end

  // Modem lines: handshake out, status in
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      REQ_TO_SEND_N <= 1'b1;
      DSR_STAT      <= 1'b0;
      CD_STAT       <= 1'b0;
      RI_STAT       <= 1'b0;
    end else begin
      REQ_TO_SEND_N <= ~(RTS_REQ & ext_rst_n_q);   // [RL14]
      DSR_STAT      <= ~DATA_SET_READY_N;          // [RL15]
      CD_STAT       <= ~CARRIER_DETECT_N;          // [RL16]
      RI_STAT       <= ~RING_INDICATOR_N;
    end
  end

  // Outgoing bytes wait in the FIFO while the shifter is busy
  logic      fifo_valid;
  rlw_byte_t fifo_data;
  rlw_tx_e   tx_q;
  wire       fifo_take = (tx_q == TX_IDLE) & ext_rst_n_q;

  rlw_fifo #(.WIDTH(`RLW_DATA_W), .DEPTH(`RLW_FIFO_DEPTH)) u_fifo (
    .clk       (CORE_CLK),
    .rst       (RST),
    .clr       (dev_rst),
    .in_valid  (USB_OUT_VALID),
    .in_ready  (USB_OUT_READY),
    .in_data   (USB_OUT_DATA),
    .out_valid (fifo_valid),
    .out_ready (fifo_take),
    .out_data  (fifo_data)
  );

  // Transmit shifter: start, eight data LSB first, stop
  logic [9:0]            tx_sh_q;
  logic [3:0]            tx_bit_q;
  logic [`RLW_BIT_W-1:0] tx_cnt_q;
  wire                   tx_load = fifo_valid & fifo_take;
  wire                   tx_bend = (tx_cnt_q == `RLW_BIT_W'(BITC - 1));
  wire                   tx_last = tx_bend & (tx_bit_q == 4'h9);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      tx_q     <= TX_IDLE;
      tx_sh_q  <= '1;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else if (dev_rst) begin
      tx_q     <= TX_IDLE;
      tx_sh_q  <= '1;
      tx_bit_q <= '0;
      tx_cnt_q <= '0;
    end else begin
      unique case (tx_q)
        TX_IDLE: begin
          if (tx_load) begin
            tx_q     <= TX_SHIFT;
            tx_sh_q  <= {1'b1, fifo_data, 1'b0};
            tx_bit_q <= '0;
            tx_cnt_q <= '0;
          end
        end
        TX_SHIFT: begin
          tx_cnt_q <= tx_bend ? '0 : tx_cnt_q + `RLW_BIT_W'(1);
          if (tx_bend) begin
            tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
            tx_bit_q <= tx_bit_q + 4'h1;
          end
          if (tx_last) tx_q <= TX_IDLE;
        end
      endcase
    end
  end

  // Line and RS485 enable track the shifter one cycle later
  wire txd_d = (tx_q == TX_SHIFT) ? tx_sh_q[0] : `RLW_TXD_IDLE;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      SER_TX_DATA         <= `RLW_TXD_IDLE;
      RS485_DRIVER_ENABLE <= 1'b0;
    end else begin
      SER_TX_DATA         <= txd_d;                  // [RL12]
      RS485_DRIVER_ENABLE <= (tx_q == TX_SHIFT);     // [RL13]
    end
  end

  // Receiver: sample at mid-bit, drop frames with a bad start
  // or stop bit; no error is reported upward.
  logic                  rxd_q;
  rlw_rx_e               rx_q;
  logic [`RLW_BIT_W-1:0] rx_cnt_q;
  logic [3:0]            rx_bit_q;
  rlw_byte_t             rx_sh_q;
  wire                   rx_smp  = (rx_cnt_q == '0);
  wire                   rx_stop = rx_smp & (rx_bit_q == 4'h9);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rxd_q        <= 1'b1;
      rx_q         <= RX_IDLE;
      rx_cnt_q     <= '0;
      rx_bit_q     <= '0;
      rx_sh_q      <= '0;
      USB_IN_VALID <= 1'b0;
      USB_IN_DATA  <= '0;
    end else begin
      rxd_q        <= SER_RX_DATA;                   // [RL12]
      USB_IN_VALID <= 1'b0;
      if (dev_rst) begin
        rx_q <= RX_IDLE;
      end else begin
        unique case (rx_q)
          RX_IDLE: begin
            if (!rxd_q) begin
              rx_q     <= RX_BUSY;
              rx_cnt_q <= `RLW_BIT_W'(BITC / 2);
              rx_bit_q <= '0;
            end
          end
          RX_BUSY: begin
            rx_cnt_q <= rx_smp ? `RLW_BIT_W'(BITC - 1) :
                        rx_cnt_q - `RLW_BIT_W'(1);
            if (rx_smp) begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == 4'h0 && rxd_q) rx_q <= RX_IDLE;
              if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9) begin
                rx_sh_q <= {rxd_q, rx_sh_q[7:1]};
              end
            end
            if (rx_stop) begin
              rx_q         <= RX_IDLE;
              USB_IN_VALID <= rxd_q;
              USB_IN_DATA  <= rx_sh_q;
            end
          end
        endcase
      end
    end
  end
endmodule : rlw_top

// file: tb/rlw_chk.sv
// Checker for the reset, LED, wake and serial pin logic
`timescale 1ns/100ps
module rlw_chk #(
  parameter int unsigned POR_CYCLES = 50,
  parameter int unsigned RI_CYCLES  = 100
) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // Reset pins
  input wire logic RESET_N_IN,
  input wire logic GEN_RESET_OUT_N_O,
  input wire logic GEN_RESET_OUT_N_OE_N,
  // LEDs and reference copy
  input wire logic TX_ACTIVITY_LED_N_OE_N,
  input wire logic RX_ACTIVITY_LED_N_OE_N,
  input wire logic OSC_REF_OUT,
  // USB link state
  input wire logic USB_SUSPEND,
  input wire logic USB_IN_XFER,
  input wire logic USB_OUT_XFER,
  input wire logic REMOTE_WAKE_EN,
  input wire logic SUSPEND_N,
  input wire logic RESUME_REQ,
  // Serial and modem pins
  input wire logic SER_TX_DATA,
  input wire logic RS485_DRIVER_ENABLE,
  input wire logic RTS_REQ,
  input wire logic REQ_TO_SEND_N,
  input wire logic DATA_SET_READY_N,
  input wire logic CARRIER_DETECT_N,
  input wire logic RING_INDICATOR_N,
  input wire logic DSR_STAT,
  input wire logic CD_STAT,
  input wire logic RI_STAT
);
  logic [31:0] up_q;
  logic [31:0] ri_q;
  logic        wake_c;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // Wake condition as the block should see it
  assign wake_c = USB_SUSPEND && REMOTE_WAKE_EN && !RING_INDICATOR_N;
  // Cycles since reset (saturates) and run length of the wake condition
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      up_q <= 32'h0;
      ri_q <= 32'h0;
    end else begin
      up_q <= (up_q == 32'hffffffff) ? up_q : up_q + 32'h1;
      ri_q <= wake_c ? ri_q + 32'h1 : 32'h0;
    end
  end
  a_por_float: assert property (
    up_q < POR_CYCLES && RESET_N_IN |-> GEN_RESET_OUT_N_OE_N)
    else $error("reset pin driven before power-up delay");
  // Lock takes some tens of cycles, so allow a margin before drive
  a_por_drive: assert property (
    up_q == POR_CYCLES + 400 && RESET_N_IN
    |-> !GEN_RESET_OUT_N_OE_N && GEN_RESET_OUT_N_O)
    else $error("reset pin not driven high after delay");
  a_ext_reset: assert property (
    $fell(RESET_N_IN) |-> ##2 (!GEN_RESET_OUT_N_OE_N && !GEN_RESET_OUT_N_O))
    else $error("reset pin not driven low");
  a_tx_led_hold: assert property (
    @(posedge CORE_CLK) disable iff (RST || !RESET_N_IN)
    USB_IN_XFER |=> !TX_ACTIVITY_LED_N_OE_N [*8])
    else $error("transmit LED pulse too short");
  a_rx_led_on: assert property (
    USB_OUT_XFER |=> !RX_ACTIVITY_LED_N_OE_N)
    else $error("receive LED not lit");
  a_osc_stop: assert property (
    USB_SUSPEND |=> !OSC_REF_OUT)
    else $error("reference output runs in suspend");
  a_sleep_flag: assert property (
    $rose(USB_SUSPEND) |=> !SUSPEND_N)
    else $error("suspend indicator not low");
  a_wake_time: assert property (
    RESUME_REQ == (ri_q == RI_CYCLES))
    else $error("wake pulse at wrong cycle");
  a_tx_idle: assert property (
    !RS485_DRIVER_ENABLE |-> SER_TX_DATA)
    else $error("serial line active without driver enable");
  a_rts_drive: assert property (
    RESET_N_IN [*2] |=> REQ_TO_SEND_N == !$past(RTS_REQ))
    else $error("request-to-send wrong");
  a_modem_copy: assert property (
    RESET_N_IN [*2] |=> {DSR_STAT, CD_STAT, RI_STAT} ==
      ~$past({DATA_SET_READY_N, CARRIER_DETECT_N, RING_INDICATOR_N}))
    else $error("modem status copy wrong");
endmodule : rlw_chk
bind rlw_top rlw_chk #(.POR_CYCLES(POR_CYCLES), .RI_CYCLES(RI_CYCLES))
  u_chk (.*);

// file: tb/rlw_peer.sv
// Serial peripheral model, 8 data bits, no parity, one stop bit
`timescale 1ns/100ps
`include "rlw_params.svh"
module rlw_peer #(
  parameter int unsigned BITC = `RLW_BIT_CYC
) (
  // Clock
  input  wire logic       clk,
  // Line from the device and line toward it
  input  wire logic       line_in,
  output logic            line_out,
  // Send request and received byte
  input  wire logic       send,
  input  wire logic [7:0] send_byte,
  output logic            got,
  output logic [7:0]      got_byte
);
  logic [9:0] fr;
  // Receiver: start edge, then mid-bit samples, LSB first
  initial begin : rx_proc
    got = 1'b0;
    got_byte = 8'h00;
    forever begin
      @(negedge line_in);
      repeat (BITC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BITC) @(posedge clk);
        got_byte[i] = line_in;
      end
      repeat (BITC) @(posedge clk);
      got = line_in;
      @(posedge clk);
      got = 1'b0;
    end
  end
  // Transmitter: line idles high; a start bit low opens each frame
  initial begin : tx_proc
    line_out = 1'b1;
    forever begin
      @(posedge clk);
      if (send) begin
        fr = {1'b1, send_byte, 1'b0};
        for (int i = 0; i < 10; i++) begin
          line_out <= fr[i];
          repeat (BITC) @(posedge clk);
        end
      end
    end
  end
endmodule : rlw_peer

// file: tb/rlw_top_tb_top.sv
// Testbench for the reset, LED, wake and serial pin logic
`timescale 1ns/100ps
module rlw_top_tb_top;
  import rlw_pkg::*;
  localparam int unsigned POR = 50;
  localparam int unsigned LED = 20;
  localparam int unsigned RIC = 100;
  // Modem rows: upper nibble dsr_n,cd_n,ri_n,rts; lower nibble expected
  localparam logic [7:0] ROWS [4] = '{8'h0f, 8'ha5, 8'h5a, 8'hf0};
  logic CORE_CLK = 1'b0, RST = 1'b1, RESET_N_IN = 1'b1, OSC_REF_IN = 1'b0;
  logic USB_SUSPEND = 1'b0, USB_IN_XFER = 1'b0, USB_OUT_XFER = 1'b0;
  logic REMOTE_WAKE_EN = 1'b0, USB_OUT_VALID = 1'b0, RTS_REQ = 1'b0;
  logic DATA_SET_READY_N = 1'b1, CARRIER_DETECT_N = 1'b1;
  logic RING_INDICATOR_N = 1'b1, SER_RX_DATA;
  rlw_byte_t USB_OUT_DATA = 8'h00, USB_IN_DATA;
  logic GEN_RESET_OUT_N_O, GEN_RESET_OUT_N_OE_N, TX_ACTIVITY_LED_N_O;
  logic TX_ACTIVITY_LED_N_OE_N, RX_ACTIVITY_LED_N_O, RX_ACTIVITY_LED_N_OE_N;
  logic OSC_REF_OUT, WORK_CLK_TICK, REF_LOCK, SUSPEND_N, RESUME_REQ;
  logic USB_OUT_READY, USB_IN_VALID, SER_TX_DATA, RS485_DRIVER_ENABLE;
  logic REQ_TO_SEND_N, DSR_STAT, CD_STAT, RI_STAT;
  logic peer_send = 1'b0, peer_got;
  logic [7:0] peer_rx;
  int errors = 0, checks = 0, n, k;
  // Core clock and a 6 MHz reference; this half period keeps the
  // reference edges off the core's rising edges, so sampling never races
  always #2 CORE_CLK = ~CORE_CLK;
  always #83.2 OSC_REF_IN = ~OSC_REF_IN;
  rlw_top #(.POR_CYCLES(POR), .LED_CYCLES(LED), .RI_CYCLES(RIC)) DUT (.*);
  rlw_peer PEER (.clk(CORE_CLK), .line_in(SER_TX_DATA),
    .line_out(SER_RX_DATA), .send(peer_send), .send_byte(8'h3c),
    .got(peer_got), .got_byte(peer_rx));
  // No test-mode pin reaches this block; the board ties it low
  // Inputs move 1 ns after the edge so sampling never races
  task automatic tick(input int c = 1);
    repeat (c) @(posedge CORE_CLK);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  // Holds the byte until ready is seen at an edge, or gives up
  task automatic push(input rlw_byte_t b, input int lim, output bit ok);
    int w;
    USB_OUT_DATA = b;
    USB_OUT_VALID = 1'b1;
    for (w = 0; w < lim && USB_OUT_READY !== 1'b1; w++) tick();
    ok = USB_OUT_READY === 1'b1;
    if (ok) tick();
  endtask : push
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  // Main sequence: power-up and rows first, then the timed and awkward cases
  initial begin : main
    bit ok, a, b;
    tick(16);
    RST = 1'b0;
    tick();
    chk("por float", 1, GEN_RESET_OUT_N_OE_N);
    for (n = 0; n < 2000 && GEN_RESET_OUT_N_OE_N !== 1'b0; n++) tick();
    chk("por delay", 1, n > POR);
    chk("por level", 1, GEN_RESET_OUT_N_O);
    $display("test power-up done");
    foreach (ROWS[i]) begin
      {DATA_SET_READY_N, CARRIER_DETECT_N, RING_INDICATOR_N, RTS_REQ}
        = ROWS[i][7:4];
      tick(2);
      chk("modem", ROWS[i][3:0], {DSR_STAT, CD_STAT, RI_STAT,
        REQ_TO_SEND_N});
    end
    $display("test modem rows done");
    USB_IN_XFER = 1'b1;
    USB_OUT_XFER = 1'b1;
    tick();
    USB_IN_XFER = 1'b0;
    USB_OUT_XFER = 1'b0;
    tick(LED - 1);
    chk("tx led on", 0, TX_ACTIVITY_LED_N_OE_N);
    USB_OUT_XFER = 1'b1;
    tick();
    USB_OUT_XFER = 1'b0;
    chk("tx led off", 1, TX_ACTIVITY_LED_N_OE_N);
    tick(LED - 1);
    chk("rx led held", 0, RX_ACTIVITY_LED_N_OE_N);
    tick();
    chk("rx led off", 1, RX_ACTIVITY_LED_N_OE_N);
    $display("test leds done");
    USB_SUSPEND = 1'b1;
    REMOTE_WAKE_EN = 1'b1;
    RING_INDICATOR_N = 1'b0;
    for (n = 0; n < 300 && RESUME_REQ !== 1'b1; n++) tick();
    chk("wake delay", RIC, n);
    chk("sleep pins", 0, {SUSPEND_N, OSC_REF_OUT});
    REMOTE_WAKE_EN = 1'b0;
    k = 0;
    repeat (RIC + 10) begin
      tick();
      if (RESUME_REQ !== 1'b0) k++;
    end
    chk("wake off", 0, k);
    USB_SUSPEND = 1'b0;
    RING_INDICATOR_N = 1'b1;
    tick(200);
    n = 0;
    k = 0;
    repeat (1250) begin
      tick();
      if (WORK_CLK_TICK === 1'b1) n++;
      if (OSC_REF_OUT === 1'b1) k++;
    end
    chk("tick rate", 1, n >= 234 && n <= 246);
    chk("ref runs", 1, k >= 500 && k <= 750);
    chk("ref lock", 1, REF_LOCK);
    chk("led pin level", 0, {TX_ACTIVITY_LED_N_O,
      RX_ACTIVITY_LED_N_O});
    $display("test suspend and clock done");
    peer_send = 1'b1;
    push(8'ha5, 10, ok);
    USB_OUT_VALID = 1'b0;
    peer_send = 1'b0;
    a = 1'b0;
    b = 1'b0;
    for (n = 0; n < 30000 && !(a && b); n++) begin
      tick();
      if (USB_IN_VALID === 1'b1) a = 1'b1;
      if (peer_got === 1'b1) b = 1'b1;
    end
    chk("rx byte", 8'h3c, USB_IN_DATA);
    chk("tx byte", 8'ha5, peer_rx);
    chk("driver on", 1, RS485_DRIVER_ENABLE);
    $display("test serial done");
    tick(1200);
    chk("driver off", 0, RS485_DRIVER_ENABLE);
    k = 0;
    do begin
      push(k[7:0], 5, ok);
      if (ok) k++;
    end while (ok && k < 30);
    chk("accepted", 17, k);
    RESET_N_IN = 1'b0;
    USB_OUT_VALID = 1'b0;
    tick(3);
    chk("ext reset pin", 0, {GEN_RESET_OUT_N_OE_N,
      GEN_RESET_OUT_N_O});
    chk("rts off", 1, REQ_TO_SEND_N);
    chk("buffer flushed", 1, USB_OUT_READY);
    RESET_N_IN = 1'b1;
    tick(4);
    chk("pin back high", 1, {GEN_RESET_OUT_N_OE_N,
      GEN_RESET_OUT_N_O});
    $display("test buffer and ext reset done");
    end_sim();
  end
  // Watchdog: the sequence needs about 24000 cycles
  initial begin : watchdog
    repeat (80000) @(posedge CORE_CLK);
    errors++;
    $display("wrong value watchdog expected done seen hang");
    end_sim();
  end
endmodule : rlw_top_tb_top
